// *** rtl/bus_write_output_microops.sv ***
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "bwo_defines.svh"
module bus_write_output_microops
    import bwo_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] instr_in,
    input wire logic instr_valid_in,
    output logic instr_ready_out,
    output logic instr_done_out,
    input wire logic [15:0] bus_dal_in,
    input wire logic bus_reply_in,
    input wire logic bus_busy_in,
    output logic [15:0] bus_dal_out,
    output logic bus_dal_oe_out,
    output logic bus_sync_out,
    output logic data_out_strobe_out,
    output logic intr_ack_out,
    output logic bus_iack_line_n_out,
    output logic bus_cycle_open_out,
    output logic byte_negative_out,
    output logic byte_zero_out,
    output logic half_carry_out,
    output logic full_carry_out,
    output logic cc_n_out,
    output logic cc_z_out,
    output logic cc_v_out,
    output logic cc_c_out,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    phase_t ph;
    main_state_t s_q;
    main_state_t s_d;
    logic [7:0] rf_a_rd;
    logic [7:0] rf_b_rd;
    logic [3:0] rf_a_addr;
    logic [3:0] rf_b_addr;
    logic rf_we;
    logic [3:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic [7:0] opc;
    logic is_stat_in;
    logic is_stat_flag;
    logic is_wib;
    logic is_wiw;
    logic is_ack;
    logic is_os;
    logic inc_two;
    logic fin3;
    logic sel_pend;
    logic [7:0] inc_k;
    logic [8:0] sum_byte;
    logic [16:0] sum_word;
    logic [4:0] sum_nib;

    // reset release through two flops
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    phase_gen i_phase_gen (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .phase_out(ph)
    );

    scratch_reg_file i_scratch_reg_file (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .a_addr_in(rf_a_addr),
        .b_addr_in(rf_b_addr),
        .c_addr_in(reg_addr_in),
        .c_rd_in(reg_rd_in),
        .we_in(rf_we),
        .waddr_in(rf_waddr),
        .wdata_in(rf_wdata),
        .a_data_out(rf_a_rd),
        .b_data_out(rf_b_rd),
        .c_data_out(reg_rdata_out)
    );

    // decode of the running micro-operation
    assign opc = s_q.instr[15:8];
    assign is_stat_in = (opc == `OPC_STAT_IN) || (opc == `OPC_STAT_IN_FLAG);
    assign is_stat_flag = (opc == `OPC_STAT_IN_FLAG);
    assign is_wib = (opc == `OPC_WR_INC_B1) || (opc == `OPC_WR_INC_B2);
    assign is_wiw = (opc == `OPC_WR_INC_W1) || (opc == `OPC_WR_INC_W2);
    assign is_ack = (opc == `OPC_WR_ACK);
    assign is_os = (opc == `OPC_OS);
    assign inc_two = (opc == `OPC_WR_INC_B2) || (opc == `OPC_WR_INC_W2);
    assign inc_k = inc_two ? `INC_TWO : `INC_ONE;

    // increment adders, byte and word
    assign sum_byte = {1'b0, rf_a_rd} + {1'b0, inc_k};
    assign sum_word = {1'b0, rf_b_rd, rf_a_rd} + {9'h000, inc_k};
    assign sum_nib = {1'b0, rf_a_rd[3:0]} + {1'b0, inc_k[3:0]};

    // does the running operation end in this microcycle
    assign fin3 = (s_q.st == ST_LOAD) || (s_q.st == ST_INC)
                  || (s_q.st == ST_ADDR && !is_wiw)
                  || (s_q.st == ST_OUT && (is_os || bus_reply_in));

    // in phase_three a finishing op lets the next one read ahead
    assign sel_pend = (ph == PH_THREE) && (s_q.st == ST_IDLE || fin3);
    assign rf_a_addr = sel_pend ? s_q.pend[3:0] : s_q.instr[3:0];
    assign rf_b_addr = sel_pend ? s_q.pend[7:4] : s_q.instr[7:4];

    // first state of a newly started micro-operation
    function automatic state_t first_state(input logic [7:0] code);
        state_t st;
        st = ST_LOAD;
        if (code == `OPC_W || code == `OPC_WR_ACK || code == `OPC_WR_INC_B1
            || code == `OPC_WR_INC_B2 || code == `OPC_WR_INC_W1 || code == `OPC_WR_INC_W2) begin
            st = ST_CHECK;
        end else if (code == `OPC_OUT_BYTE || code == `OPC_OW || code == `OPC_OS) begin
            st = ST_OUT;
        end
        return st;
    endfunction

    // sequencer: one pass per phase
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.sync = 1'b0;
        s_d.iack = 1'b0;
        s_d.iack_line_n = 1'b1;
        rf_we = 1'b0;
        rf_waddr = s_q.instr[3:0];
        rf_wdata = `ZERO_BYTE;
        unique case (ph)
            PH_ONE: begin
                // strobe for the next phase, address already on the bus
                if (s_q.st == ST_ADDR) begin
                    s_d.sync = 1'b1;
                    s_d.iack = is_ack;
                end
                // upper half of a word increment
                if (s_q.st == ST_INC) begin
                    rf_we = 1'b1;
                    rf_waddr = s_q.instr[7:4];
                    rf_wdata = s_q.sum[15:8];
                end
            end
            PH_TWO: begin
                // status word low byte first, no bus handshake
                if (s_q.st == ST_LOAD && is_stat_in) begin
                    rf_we = 1'b1;
                    rf_wdata = bus_dal_in[7:0];
                    s_d.neg_b = bus_dal_in[`BYTE_SIGN_BIT];
                    s_d.zero_b = (bus_dal_in[7:0] == `ZERO_BYTE);
                    if (is_stat_flag) begin
                        s_d.n = bus_dal_in[`BYTE_SIGN_BIT];
                        s_d.z = (bus_dal_in[7:0] == `ZERO_BYTE);
                        s_d.v = 1'b0;
                    end
                end
            end
            PH_THREE: begin
                s_d.fin = fin3;
                s_d.start = (s_q.st == ST_IDLE || fin3) && s_q.pend_v;
                s_d.go = !bus_busy_in && !bus_reply_in;
                s_d.reply_seen = (s_q.st == ST_OUT) && bus_reply_in;
                // status word upper byte into the next register
                if (s_q.st == ST_LOAD && is_stat_in) begin
                    rf_we = 1'b1;
                    rf_waddr = s_q.instr[3:0] + `REG_NEXT;
                    rf_wdata = bus_dal_in[15:8];
                end
                // byte increment touches a_port_register only
                if (s_q.st == ST_ADDR && is_wib) begin
                    rf_we = 1'b1;
                    rf_wdata = sum_byte[7:0];
                    s_d.neg_b = sum_byte[`BYTE_SIGN_BIT];
                    s_d.zero_b = (sum_byte[7:0] == `ZERO_BYTE);
                    s_d.carry_h = sum_nib[`NIB_CARRY_BIT];
                    s_d.carry_f = sum_byte[`BYTE_CARRY_BIT];
                end
                // word increment: low byte now, upper in next microcycle
                if (s_q.st == ST_ADDR && is_wiw) begin
                    rf_we = 1'b1;
                    rf_wdata = sum_word[7:0];
                    s_d.sum = sum_word[15:0];
                    s_d.neg_b = sum_word[`WORD_SIGN_BIT];
                    s_d.zero_b = (sum_word[15:0] == `ZERO_WORD);
                    s_d.carry_h = sum_nib[`NIB_CARRY_BIT];
                    s_d.carry_f = sum_word[`WORD_CARRY_BIT];
                end
            end
            PH_FOUR: begin
                // address and data leave the bus at the end of phase_four
                s_d.dal_oe = 1'b0;
                s_d.addr_valid = 1'b0;
                s_d.dout = 1'b0;
                if (s_q.st != ST_IDLE && s_q.fin) begin
                    s_d.done = 1'b1;
                    if (s_q.st == ST_OUT) begin
                        s_d.cycle_open = 1'b0;
                    end
                end
                if (s_q.st == ST_IDLE || s_q.fin) begin
                    if (s_q.start) begin
                        s_d.instr = s_q.pend;
                        s_d.pend_v = 1'b0;
                        s_d.st = first_state(s_q.pend[15:8]);
                        // output data from phase_one, strobe too except for OPC_OS, no write needed
                        if (first_state(s_q.pend[15:8]) == ST_OUT) begin
                            s_d.dal = {rf_b_rd, rf_a_rd};
                            s_d.dal_oe = 1'b1;
                            s_d.dout = (s_q.pend[15:8] != `OPC_OS);
                        end
                    end else begin
                        s_d.st = ST_IDLE;
                    end
                end else if (s_q.st == ST_CHECK && s_q.go) begin
                    // address microcycle follows the clean check
                    s_d.st = ST_ADDR;
                    s_d.dal = {rf_b_rd, rf_a_rd};
                    s_d.dal_oe = 1'b1;
                    s_d.addr_valid = 1'b1;
                    s_d.cycle_open = !is_ack;
                end else if (s_q.st == ST_ADDR) begin
                    s_d.st = ST_INC;
                end else if (s_q.st == ST_OUT) begin
                    // no reply yet: keep data and strobe up
                    s_d.dal_oe = 1'b1;
                    s_d.dout = !is_os;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // register port writes only while the sequencer is idle
        if (s_q.st == ST_IDLE && reg_wr_in) begin
            rf_we = 1'b1;
            rf_waddr = reg_addr_in;
            rf_wdata = reg_wdata_in;
        end
        // one-deep instruction holding slot
        if (s_q.ready && instr_valid_in) begin
            s_d.pend = instr_in;
            s_d.pend_v = 1'b1;
        end
        s_d.ready = !s_d.pend_v;
    end

    // state register
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.iack_line_n <= 1'b1;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign instr_ready_out = s_q.ready;
    assign instr_done_out = s_q.done;
    assign bus_dal_out = s_q.dal;
    assign bus_dal_oe_out = s_q.dal_oe;
    assign bus_sync_out = s_q.sync;
    assign data_out_strobe_out = s_q.dout;
    assign intr_ack_out = s_q.iack;
    assign bus_iack_line_n_out = s_q.iack_line_n;
    assign bus_cycle_open_out = s_q.cycle_open;
    assign byte_negative_out = s_q.neg_b;
    assign byte_zero_out = s_q.zero_b;
    assign half_carry_out = s_q.carry_h;
    assign full_carry_out = s_q.carry_f;
    assign cc_n_out = s_q.n;
    assign cc_z_out = s_q.z;
    assign cc_v_out = s_q.v;
    assign cc_c_out = s_q.c;

    // checks on the bus sequencing
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n);

    a_sync_phase_two: assert property (bus_sync_out |-> (ph == PH_TWO) && s_q.addr_valid)
        else $error("sync strobe outside phase two of address microcycle");
    a_iack_with_sync: assert property (intr_ack_out |-> bus_sync_out && is_ack)
        else $error("acknowledge not aligned with sync");
    a_addr_one_cycle: assert property ($rose(s_q.addr_valid) |-> (ph == PH_ONE)
        ##0 s_q.addr_valid[*4] ##1 !s_q.addr_valid)
        else $error("address not valid for exactly one microcycle");
    a_check_stall: assert property ((s_q.st == ST_CHECK && ph == PH_THREE
        && (bus_busy_in || bus_reply_in)) |=> ##1 (s_q.st == ST_CHECK && !bus_dal_oe_out))
        else $error("write started while bus busy");
    a_isw_no_wait: assert property ((s_q.st == ST_LOAD && ph == PH_ONE)
        |-> ##3 s_q.fin ##1 instr_done_out)
        else $error("status word load did not finish in one microcycle");
    a_dout_after_addr: assert property ($rose(data_out_strobe_out)
        |-> (ph == PH_ONE) && !s_q.addr_valid)
        else $error("data strobe not at phase one after address");
    a_out_hold_reply: assert property ((data_out_strobe_out && ph == PH_FOUR && !s_q.reply_seen)
        |=> data_out_strobe_out && !instr_done_out)
        else $error("output ended without reply");
    a_addr_both_bytes: assert property (bus_sync_out |-> bus_dal_out == {rf_b_rd, rf_a_rd})
        else $error("address word not both register bytes");
    a_iack_line_off: assert property (s_q.addr_valid |-> bus_iack_line_n_out)
        else $error("iack line asserted during address");
    a_os_no_strobe: assert property ((s_q.st == ST_OUT && is_os) |-> !data_out_strobe_out)
        else $error("output status raised the data strobe");
    a_write_one_cycle: assert property (($rose(s_q.addr_valid) && !is_wiw)
        |-> ##4 (s_q.st != ST_ADDR && s_q.st != ST_INC))
        else $error("non-word write took more than one microcycle");

    c_write_done: cover property ($fell(s_q.addr_valid) && !bus_dal_oe_out);
    c_output_done: cover property ($fell(data_out_strobe_out) && instr_done_out);
    c_busy_stall: cover property (s_q.st == ST_CHECK && ph == PH_THREE && bus_busy_in);
    c_word_inc: cover property (s_q.st == ST_INC && ph == PH_ONE);
endmodule // bus_write_output_microops

// *** common/bwo_defines.svh ***
`ifndef BWO_DEFINES_SVH
`define BWO_DEFINES_SVH

// phase codes, one-hot
`define PH_ONE_CODE 4'h1
`define PH_TWO_CODE 4'h2
`define PH_THREE_CODE 4'h4
`define PH_FOUR_CODE 4'h8

// sequencer state codes, one-hot
`define ST_IDLE_CODE 6'h01
`define ST_LOAD_CODE 6'h02
`define ST_CHECK_CODE 6'h04
`define ST_ADDR_CODE 6'h08
`define ST_INC_CODE 6'h10
`define ST_OUT_CODE 6'h20

// upper opcode byte of each micro-operation
`define OPC_STAT_IN 8'hE6
`define OPC_STAT_IN_FLAG 8'hE7
`define OPC_WR_INC_B1 8'hF1
`define OPC_WR_INC_W1 8'hF3
`define OPC_WR_INC_B2 8'hF5
`define OPC_WR_INC_W2 8'hF7
`define OPC_W 8'hF9
`define OPC_WR_ACK 8'hFB
`define OPC_OUT_BYTE 8'hFC
`define OPC_OW 8'hFD
`define OPC_OS 8'hFE

// increments and arithmetic bit positions
`define INC_ONE 8'h01
`define INC_TWO 8'h02
`define REG_NEXT 4'h1
`define NIB_CARRY_BIT 4
`define BYTE_SIGN_BIT 7
`define BYTE_CARRY_BIT 8
`define WORD_SIGN_BIT 15
`define WORD_CARRY_BIT 16
`define ZERO_BYTE 8'h00
`define ZERO_WORD 16'h0000
`endif

// *** common/bwo_pkg.sv ***
`include "bwo_defines.svh"
package bwo_pkg;
    typedef enum logic [3:0] {
        PH_ONE = `PH_ONE_CODE,
        PH_TWO = `PH_TWO_CODE,
        PH_THREE = `PH_THREE_CODE,
        PH_FOUR = `PH_FOUR_CODE
    } phase_t;

    typedef enum logic [5:0] {
        ST_IDLE = `ST_IDLE_CODE,
        ST_LOAD = `ST_LOAD_CODE,
        ST_CHECK = `ST_CHECK_CODE,
        ST_ADDR = `ST_ADDR_CODE,
        ST_INC = `ST_INC_CODE,
        ST_OUT = `ST_OUT_CODE
    } state_t;

    typedef struct packed {
        phase_t ph;
    } phase_state_t;

    typedef struct packed {
        logic [15:0][7:0] mem;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } regfile_state_t;

    typedef struct packed {
        state_t st;
        logic [15:0] instr;
        logic [15:0] pend;
        logic pend_v;
        logic ready;
        logic [15:0] sum;
        logic fin;
        logic start;
        logic go;
        logic reply_seen;
        logic addr_valid;
        logic [15:0] dal;
        logic dal_oe;
        logic sync;
        logic dout;
        logic iack;
        logic iack_line_n;
        logic done;
        logic cycle_open;
        logic neg_b;
        logic zero_b;
        logic carry_h;
        logic carry_f;
        logic n;
        logic z;
        logic v;
        logic c;
    } main_state_t;
endpackage

// *** rtl/phase_gen.sv ***
`timescale 1ns/1ps
module phase_gen
    import bwo_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    output phase_t phase_out
);
    phase_state_t s_q;
    phase_state_t s_d;

    // four clocks per microcycle, phase_one first after reset
    always_comb begin
        s_d = s_q;
        unique case (s_q.ph)
            PH_ONE: s_d.ph = PH_TWO;
            PH_TWO: s_d.ph = PH_THREE;
            PH_THREE: s_d.ph = PH_FOUR;
            PH_FOUR: s_d.ph = PH_ONE;
            default: s_d.ph = PH_ONE;
        endcase
    end

    // phase register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q.ph <= PH_ONE;
        end else begin
            s_q <= s_d;
        end
    end

    assign phase_out = s_q.ph;
endmodule // phase_gen

// *** rtl/micro_reg_file.sv ***
`timescale 1ns/1ps
module scratch_reg_file
    import bwo_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] a_addr_in,
    input wire logic [3:0] b_addr_in,
    input wire logic [3:0] c_addr_in,
    input wire logic c_rd_in,
    input wire logic we_in,
    input wire logic [3:0] waddr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] a_data_out,
    output logic [7:0] b_data_out,
    output logic [7:0] c_data_out
);
    regfile_state_t s_q;
    regfile_state_t s_d;

    // one write port, three registered read ports with write-through
    always_comb begin
        s_d = s_q;
        if (we_in) begin
            s_d.mem[waddr_in] = wdata_in;
        end
        s_d.a = (we_in && waddr_in == a_addr_in) ? wdata_in : s_q.mem[a_addr_in];
        s_d.b = (we_in && waddr_in == b_addr_in) ? wdata_in : s_q.mem[b_addr_in];
        if (c_rd_in) begin
            s_d.c = (we_in && waddr_in == c_addr_in) ? wdata_in : s_q.mem[c_addr_in];
        end
    end

    // storage register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign a_data_out = s_q.a;
    assign b_data_out = s_q.b;
    assign c_data_out = s_q.c;
endmodule // scratch_reg_file

// *** bench/bus_peripheral_model.sv ***
`timescale 1ns/1ps
module bus_peripheral_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic strobe_in,
    input wire logic dal_oe_in,
    input wire logic [15:0] dal_in,
    input wire logic stat_en_in,
    input wire logic [15:0] stat_word_in,
    input wire logic [3:0] slow_in,
    output logic reply_out,
    output logic [15:0] line_out,
    output logic [15:0] latched_out,
    output int latch_cnt_out
);
    logic [3:0] wait_q;
    logic seen_q;
    logic [15:0] last_q;
    // released lines show stat_word_in when stat_en_in is set, else the inverse of the last value, never a stale copy
    assign line_out = dal_oe_in ? dal_in : (stat_en_in ? stat_word_in : ~last_q);
    // latch on the first strobe cycle, answer slow_in + 1 cycles after the strobe rises
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reply_out <= 1'b0;
            wait_q <= 4'h0;
            seen_q <= 1'b0;
            last_q <= 16'h0000;
            latched_out <= 16'h0000;
            latch_cnt_out <= 0;
        end else begin
            last_q <= line_out;
            if (strobe_in && !seen_q) begin
                latched_out <= line_out;
                latch_cnt_out <= latch_cnt_out + 1;
            end
            seen_q <= strobe_in;
            wait_q <= strobe_in ? wait_q + 4'h1 : 4'h0;
            reply_out <= strobe_in && (wait_q >= slow_in);
        end
    end
endmodule // bus_peripheral_model

// *** bench/bus_write_output_microops_bench.sv ***
`timescale 1ns/1ps
module bus_write_output_microops_bench;
    import bwo_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic instr_valid_in = 1'b0;
    logic busy = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic stat_en = 1'b0;
    logic [15:0] stat_word = 16'h0000;
    logic [3:0] slow = 4'h0;
    logic ready, done, reply, oe, sync, strobe, iack, iack_n, open;
    logic bneg, bzero, hcarry, fcarry, n, z, v, c;
    logic [15:0] dal_out, line, latched;
    logic [7:0] rdata;
    int latch_cnt, error_cnt = 0, comparisons = 0;
    int sync_cnt = 0, strobe_cnt = 0, run = 0, last_run = 0;
    logic [15:0] sync_addr;
    logic sync_iack;
    logic [7:0] rv;

    always #12.5 sys_clk_in = ~sys_clk_in;

    bus_write_output_microops i_bus_write_output_microops (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
        .instr_ready_out(ready), .instr_done_out(done), .bus_dal_in(line),
        .bus_reply_in(reply), .bus_busy_in(busy), .bus_dal_out(dal_out),
        .bus_dal_oe_out(oe), .bus_sync_out(sync), .data_out_strobe_out(strobe),
        .intr_ack_out(iack), .bus_iack_line_n_out(iack_n), .bus_cycle_open_out(open),
        .byte_negative_out(bneg), .byte_zero_out(bzero), .half_carry_out(hcarry),
        .full_carry_out(fcarry), .cc_n_out(n), .cc_z_out(z), .cc_v_out(v), .cc_c_out(c),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata));

    bus_peripheral_model i_bus_peripheral_model (.clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .strobe_in(strobe), .dal_oe_in(oe), .dal_in(dal_out), .stat_en_in(stat_en),
        .stat_word_in(stat_word), .slow_in(slow), .reply_out(reply), .line_out(line),
        .latched_out(latched), .latch_cnt_out(latch_cnt));

    // bus watcher: address at sync, strobe count, length of each drive run
    always @(negedge sys_clk_in) begin
        if (sync === 1'b1) begin
            sync_addr = dal_out;
            sync_iack = iack;
            sync_cnt++;
        end
        if (strobe === 1'b1) strobe_cnt++;
        if (oe === 1'b1) run++;
        else if (run != 0) begin
            last_run = run;
            run = 0;
        end
    end

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a);
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        rv = rdata;
    endtask

    // hand over one micro-instruction and wait for its completion pulse
    task automatic run_op(input logic [15:0] op);
        int k;
        @(negedge sys_clk_in);
        for (k = 0; k < 100 && ready !== 1'b1; k++) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= op;
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge sys_clk_in);
        chk(16'h0001, {15'h0000, done});
    endtask

    task automatic t_status_word();
        busy <= 1'b1;
        stat_en <= 1'b1;
        stat_word <= 16'h8000;
        run_op(16'hE704);
        busy <= 1'b0;
        stat_en <= 1'b0;
        rreg(4'h4);
        chk(16'h0000, {8'h00, rv});
        rreg(4'h5);
        chk(16'h0080, {8'h00, rv});
        chk(16'h0005, {12'h000, bneg, bzero, n, z});
        chk(16'h0000, {14'h0000, v, c});
    endtask

    task automatic t_write_out();
        int s0;
        wreg(4'h2, 8'h34);
        wreg(4'h3, 8'h12);
        wreg(4'h8, 8'hCD);
        wreg(4'h9, 8'hAB);
        busy <= 1'b1;
        s0 = sync_cnt;
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= 16'hF932;
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
        chk(16'h0000, 16'(sync_cnt - s0));
        busy <= 1'b0;
        repeat (30) @(negedge sys_clk_in);
        chk(16'h0001, 16'(sync_cnt - s0));
        chk(16'h1234, sync_addr);
        chk(16'h0004, 16'(last_run));
        chk(16'h0001, {15'h0000, open});
        rreg(4'h2);
        chk(16'h0034, {8'h00, rv});
        slow <= 4'h5;
        s0 = latch_cnt;
        run_op(16'hFD98);
        chk(16'h0001, 16'(latch_cnt - s0));
        chk(16'hABCD, latched);
        chk(16'h0000, {15'h0000, open});
        slow <= 4'h0;
    endtask

    task automatic t_increments();
        wreg(4'hA, 8'hFF);
        wreg(4'hB, 8'h5C);
        run_op(16'hF5BA);
        rreg(4'hA);
        chk(16'h0001, {8'h00, rv});
        chk(16'h000D, {10'h000, bneg, bzero, hcarry, fcarry, n, z});
        wreg(4'h6, 8'hFF);
        wreg(4'h7, 8'h12);
        run_op(16'hF376);
        rreg(4'h6);
        chk(16'h0000, {8'h00, rv});
        rreg(4'h7);
        chk(16'h0013, {8'h00, rv});
        chk(16'h0009, {10'h000, bneg, bzero, hcarry, fcarry, n, z});
        rreg(4'hB);
        chk(16'h005C, {8'h00, rv});
    endtask

    task automatic t_ack_out();
        int s0;
        run_op(16'hFB32);
        chk(16'h0001, {15'h0000, sync_iack});
        chk(16'h0001, {15'h0000, iack_n});
        chk(16'h0000, {15'h0000, open});
        wreg(4'h1, 8'h5A);
        run_op(16'hF911);
        chk(16'h5A5A, sync_addr);
        chk(16'h0000, {15'h0000, sync_iack});
        run_op(16'hFC11);
        chk(16'h5A5A, latched);
        s0 = strobe_cnt;
        run_op(16'hFE98);
        chk(16'h0000, 16'(strobe_cnt - s0));
        chk(16'h0004, 16'(last_run));
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #(25 * 8000);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        chk(16'h0003, {14'h0000, ready, iack_n});
        t_status_word();
        t_write_out();
        t_increments();
        t_ack_out();
        wrap_up();
    end
endmodule // bus_write_output_microops_bench
